/* verilog/swr_map.svh */
`ifndef SWR_MAP_SVH
`define SWR_MAP_SVH

// Register indices; the APB byte address is four times the index.
`define SWR_IDX_FLAGS  18'h0c000
`define SWR_IDX_BANK   18'h0c002
`define SWR_IDX_REV    18'h0c004
`define SWR_IDX_SPEED  18'h0c008
`define SWR_IDX_PWR    18'h0c00a
`define SWR_IDX_INTEN  18'h0c00e
`define SWR_IDX_EVT    18'h0c010
`define SWR_IDX_BKPT   18'h0c014
`define SWR_IDX_DIAG   18'h0c03c
`define SWR_BYTE(i)    ((i) << 2)

// Power and wake control bit positions.
`define SWR_PWR_HALT   0
`define SWR_PWR_SLEEP  1
`define SWR_PWR_BOOST  2
`define SWR_PWR_GPI    4
`define SWR_PWR_HOSTP  7
`define SWR_PWR_SPI    8
`define SWR_PWR_FSER   9
`define SWR_PWR_OTG    11
`define SWR_PWR_HD1    12
`define SWR_PWR_HD2    14
`define SWR_PWR_WMASK  16'h5b93

// Event status bit positions.
`define SWR_EVT_HPINT  0
`define SWR_EVT_PUMP   1

// Reset values and field masks.
`define SWR_BANK_RST   16'h0100
`define SWR_BANK_MASK  16'hfff0
`define SWR_SPEED_RST  16'h000f
`define SWR_SPEED_MASK 16'h000f
`define SWR_REV_VALUE  16'h0a5a
`define SWR_ZERO16     16'h0000

// Address space.
`define SWR_ROM_ENTRY  16'hff00
`define SWR_CTRL_HI    8'hc0
`define SWR_ROM_HI3    3'h7
`define SWR_TEST_GPIO  25'h1f8ff00

// Timing.
`define SWR_CLK_KHZ    100000
`define SWR_REF_KHZ    12000
`define SWR_RST_REFCYC 16
`define SWR_RST_CYC    ((`SWR_RST_REFCYC * `SWR_CLK_KHZ + `SWR_REF_KHZ - 1) / `SWR_REF_KHZ)
`define SWR_BOOT_MS    200
`define SWR_TEST_MS    3

`endif

/* verilog/swr_pkg.sv */
package swr_pkg;

	typedef enum logic [2:0] {
		SWR_PINRST,
		SWR_BOOT,
		SWR_RUN,
		SWR_SLEEP,
		SWR_WAKE
	} swr_state_e;

	typedef struct packed {
		logic n;
		logic v;
		logic c;
		logic z;
	} swr_flag_s;

	typedef struct packed {
		swr_state_e  st;
		logic [24:0] cnt;
		logic [18:0] testcnt;
		logic [7:0]  rstcnt;
		logic [3:0]  divcnt;
		logic [15:0] bank;
		logic [15:0] speed;
		logic [15:0] pwr;
		logic [15:0] inten;
		logic [15:0] bkpt;
		logic [15:0] diag;
		logic [15:0] evt;
		logic [15:0] cause;
		logic [31:0] prdata;
		logic [15:0] memaddr;
		logic        ident_q;
		logic        int0_q;
		logic        start;
		logic        dummy;
		logic        usbrst;
		logic        ctrl_sel;
		logic        rom_sel;
	} swr_state_s;

endpackage

/* verilog/swr_flag_unit.sv */
`include "swr_map.svh"

module swr_flag_unit
	import swr_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_clear,
	input  wire logic        i_alu_valid,
	input  wire logic        i_alu_sub,
	input  wire logic [15:0] i_alu_a,
	input  wire logic [15:0] i_alu_b,
	output logic      [3:0]  o_flags
);

	swr_flag_s   r;
	swr_flag_s   n;
	logic [16:0] res;

	always_comb
	begin
		n = r;
		res = i_alu_sub ? ({1'b0, i_alu_a} - {1'b0, i_alu_b})
		                : ({1'b0, i_alu_a} + {1'b0, i_alu_b});
		if (i_clear)
		begin
			n = '0;
		end
		else if (i_alu_valid)
		begin
			n.n = res[15];
			n.v = (res[15] != i_alu_a[15]) &&
			      ((i_alu_a[15] ^ i_alu_b[15]) == i_alu_sub);
			n.c = res[16];
			n.z = (res[15:0] == `SWR_ZERO16);
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			r <= '0;
		else
			r <= n;
	end

	assign o_flags = {r.n, r.v, r.c, r.z};

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	a_zero_flag_res: assert property (i_alu_valid && !i_clear |=>
		r.z == (($past(i_alu_sub) ? $past(i_alu_a) - $past(i_alu_b) :
		$past(i_alu_a) + $past(i_alu_b)) == `SWR_ZERO16))
		else $error("zero flag does not match last result");
	a_carry_borrow: assert property (i_alu_valid && !i_clear &&
		i_alu_sub |=> r.c == ($past(i_alu_a) < $past(i_alu_b)))
		else $error("borrow flag wrong after subtraction");
	a_neg_msb: assert property (i_alu_valid && !i_clear |=>
		r.n == $past(res[15]))
		else $error("negative flag does not follow result msb");

endmodule // swr_flag_unit

/* verilog/swr_sleep_ctrl.sv */
`include "swr_map.svh"

module swr_sleep_ctrl
	import swr_pkg::*;
#(
	parameter int BOOT_CYC = `SWR_BOOT_MS * `SWR_CLK_KHZ,
	parameter int TEST_CYC = `SWR_TEST_MS * `SWR_CLK_KHZ
)
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [17:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_alu_valid,
	input  wire logic        i_alu_sub,
	input  wire logic [15:0] i_alu_a,
	input  wire logic [15:0] i_alu_b,
	input  wire logic        i_global_int_en,
	input  wire logic [15:0] i_cpu_addr,
	output logic             o_ctrl_sel,
	output logic             o_rom_sel,
	output logic             o_cpu_clk_en,
	output logic             o_cpu_run,
	output logic             o_cpu_start,
	output logic      [15:0] o_start_addr,
	input  wire logic        i_reset_pin_n,
	input  wire logic [15:0] i_mem_addr,
	output logic      [15:0] o_mem_addr,
	output logic             o_gpio_hold,
	output logic      [24:0] o_gpio_test_oe,
	output logic             o_crystal_output_en,
	output logic             o_pll_en,
	output logic             o_booster_en,
	output logic             o_usb_xcvr_en,
	input  wire logic        i_boost_ok,
	input  wire logic        i_charge_pump_on,
	input  wire logic        i_usb1_resume,
	input  wire logic        i_usb2_resume,
	input  wire logic        i_otg_bus_supply,
	input  wire logic        i_otg_identify_input,
	input  wire logic        i_parallel_host_port_rd,
	input  wire logic        i_fast_serial_port_rd,
	input  wire logic        i_spi_rd,
	input  wire logic        i_interrupt_zero_input,
	output logic             o_read_dummy,
	output logic             o_host_port_interrupt,
	input  wire logic        i_usb_bus_reset,
	output logic             o_usb_reg_reset
);

	localparam logic [24:0] BOOT_LAST = 25'(BOOT_CYC - 1);
	localparam logic [18:0] TEST_LOAD = 19'(TEST_CYC);
	localparam logic [7:0]  RST_CYC   = 8'(`SWR_RST_CYC);

	swr_state_s r;
	swr_state_s n;
	logic [3:0]  flags;
	logic [15:0] wake_hit;
	logic        any_wake;
	logic        usb_wake;
	logic        read_wake;
	logic        wr;
	logic        rd_setup;
	logic        hit;
	logic [15:0] wdat;

	swr_flag_unit u_flags (
		.i_ref_clk   (i_ref_clk),
		.i_sys_rst   (i_sys_rst),
		.i_clear     (r.st == SWR_PINRST),
		.i_alu_valid (i_alu_valid),
		.i_alu_sub   (i_alu_sub),
		.i_alu_a     (i_alu_a),
		.i_alu_b     (i_alu_b),
		.o_flags     (flags)
	);

	// Each source only counts when its enable bit is set.
	always_comb
	begin
		wake_hit = '0;
		wake_hit[`SWR_PWR_HD1] = i_usb1_resume;
		wake_hit[`SWR_PWR_HD2] = i_usb2_resume;
		wake_hit[`SWR_PWR_OTG] = i_otg_bus_supply ||
		                         (i_otg_identify_input ^ r.ident_q);
		wake_hit[`SWR_PWR_HOSTP] = i_parallel_host_port_rd;
		wake_hit[`SWR_PWR_FSER] = i_fast_serial_port_rd;
		wake_hit[`SWR_PWR_SPI] = i_spi_rd;
		wake_hit[`SWR_PWR_GPI] = i_interrupt_zero_input ^ r.int0_q;
		wake_hit = wake_hit & r.pwr & `SWR_PWR_WMASK;
	end

	assign any_wake  = |wake_hit;
	assign usb_wake  = wake_hit[`SWR_PWR_HD1] | wake_hit[`SWR_PWR_HD2];
	assign read_wake = wake_hit[`SWR_PWR_HOSTP] | wake_hit[`SWR_PWR_FSER] |
	                   wake_hit[`SWR_PWR_SPI];
	assign wr        = i_psel && i_penable && i_pwrite;
	assign rd_setup  = i_psel && !i_penable && !i_pwrite;
	assign wdat      = i_pwdata[15:0];

	always_comb
	begin
		case (i_paddr)
			`SWR_BYTE(`SWR_IDX_FLAGS),
			`SWR_BYTE(`SWR_IDX_BANK),
			`SWR_BYTE(`SWR_IDX_REV),
			`SWR_BYTE(`SWR_IDX_SPEED),
			`SWR_BYTE(`SWR_IDX_PWR),
			`SWR_BYTE(`SWR_IDX_INTEN),
			`SWR_BYTE(`SWR_IDX_EVT),
			`SWR_BYTE(`SWR_IDX_BKPT),
			`SWR_BYTE(`SWR_IDX_DIAG): hit = 1'b1;
			default:                  hit = 1'b0;
		endcase
	end

	always_comb
	begin
		n = r;
		n.start = 1'b0;
		n.dummy = 1'b0;
		n.ident_q = i_otg_identify_input;
		n.int0_q = i_interrupt_zero_input;
		n.usbrst = i_usb_bus_reset;
		n.ctrl_sel = (i_cpu_addr[15:8] == `SWR_CTRL_HI);
		n.rom_sel = (i_cpu_addr[15:13] == `SWR_ROM_HI3);
		n.divcnt = (r.st != SWR_RUN || r.divcnt == r.speed[3:0]) ?
		           4'h0 : r.divcnt + 4'h1;
		if (r.testcnt != 19'h0)
			n.testcnt = r.testcnt - 19'h1;

		// Read data is captured in the setup cycle so it is stable in access.
		if (rd_setup)
		begin
			case (i_paddr)
				`SWR_BYTE(`SWR_IDX_FLAGS):
					n.prdata = {27'h0, i_global_int_en, flags};
				`SWR_BYTE(`SWR_IDX_BANK):  n.prdata = {16'h0, r.bank};
				`SWR_BYTE(`SWR_IDX_REV):   n.prdata = {16'h0, `SWR_REV_VALUE};
				`SWR_BYTE(`SWR_IDX_SPEED): n.prdata = {16'h0, r.speed};
				`SWR_BYTE(`SWR_IDX_PWR):
				begin
					n.prdata = {16'h0, r.pwr};
					n.prdata[`SWR_PWR_BOOST] = i_boost_ok;
				end
				`SWR_BYTE(`SWR_IDX_INTEN): n.prdata = {16'h0, r.inten};
				`SWR_BYTE(`SWR_IDX_EVT):   n.prdata = {16'h0, r.evt};
				`SWR_BYTE(`SWR_IDX_BKPT):  n.prdata = {16'h0, r.bkpt};
				// Reads here return the last wake cause, writes set diagnostics.
				`SWR_BYTE(`SWR_IDX_DIAG):  n.prdata = {16'h0, r.cause};
				default:                   n.prdata = 32'h0;
			endcase
		end

		if (wr)
		begin
			case (i_paddr)
				`SWR_BYTE(`SWR_IDX_BANK):  n.bank = wdat & `SWR_BANK_MASK;
				`SWR_BYTE(`SWR_IDX_SPEED): n.speed = wdat & `SWR_SPEED_MASK;
				`SWR_BYTE(`SWR_IDX_PWR):   n.pwr = wdat & `SWR_PWR_WMASK;
				`SWR_BYTE(`SWR_IDX_INTEN): n.inten = wdat;
				`SWR_BYTE(`SWR_IDX_EVT):   n.evt = r.evt & ~wdat;
				`SWR_BYTE(`SWR_IDX_BKPT):  n.bkpt = wdat;
				`SWR_BYTE(`SWR_IDX_DIAG):  n.diag = wdat;
				default:                   n.bkpt = n.bkpt;
			endcase
		end

		case (r.st)
			SWR_PINRST:
			begin
				if (i_reset_pin_n)
				begin
					n.st = SWR_BOOT;
					n.cnt = '0;
				end
			end
			SWR_BOOT, SWR_WAKE:
			begin
				n.cnt = r.cnt + 25'h1;
				if (r.cnt == BOOT_LAST)
				begin
					n.st = SWR_RUN;
					n.cnt = '0;
					if (r.st == SWR_BOOT)
					begin
						n.start = 1'b1;
						n.testcnt = TEST_LOAD;
					end
				end
			end
			SWR_RUN:
			begin
				if (n.pwr[`SWR_PWR_SLEEP])
				begin
					n.st = SWR_SLEEP;
					if (i_charge_pump_on)
						n.evt[`SWR_EVT_PUMP] = 1'b1;
				end
			end
			SWR_SLEEP:
			begin
				if (any_wake)
				begin
					n.st = SWR_WAKE;
					n.cnt = '0;
					n.pwr[`SWR_PWR_SLEEP] = 1'b0;
					n.cause = wake_hit;
					n.dummy = read_wake;
					if (usb_wake)
						n.evt[`SWR_EVT_HPINT] = 1'b1;
				end
			end
			default: n.st = SWR_PINRST;
		endcase

		// A pin held low long enough restores every register default.
		n.rstcnt = i_reset_pin_n ? 8'h0 :
		           (r.rstcnt == RST_CYC ? r.rstcnt : r.rstcnt + 8'h1);
		if (!i_reset_pin_n && r.rstcnt == RST_CYC)
		begin
			n.st = SWR_PINRST;
			n.cnt = '0;
			n.testcnt = '0;
			n.bank = `SWR_BANK_RST;
			n.speed = `SWR_SPEED_RST;
			n.pwr = '0;
			n.inten = '0;
			n.bkpt = '0;
			n.diag = '0;
			n.evt = '0;
			n.cause = '0;
		end
		n.memaddr = (n.st == SWR_SLEEP) ? `SWR_ZERO16 : i_mem_addr;
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			r <= '0;
			r.st <= SWR_BOOT;
			r.bank <= `SWR_BANK_RST;
			r.speed <= `SWR_SPEED_RST;
		end
		else
		begin
			r <= n;
		end
	end

	assign o_prdata = r.prdata;
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !hit;
	assign o_ctrl_sel = r.ctrl_sel;
	assign o_rom_sel = r.rom_sel;
	assign o_cpu_run = (r.st == SWR_RUN);
	assign o_cpu_clk_en = o_cpu_run && (r.divcnt == 4'h0);
	assign o_cpu_start = r.start;
	assign o_start_addr = `SWR_ROM_ENTRY;
	assign o_mem_addr = r.memaddr;
	assign o_gpio_hold = (r.st == SWR_SLEEP);
	assign o_gpio_test_oe = (r.testcnt != 19'h0) ? `SWR_TEST_GPIO : 25'h0;
	assign o_crystal_output_en = (r.st != SWR_SLEEP);
	assign o_pll_en = (r.st != SWR_SLEEP);
	assign o_booster_en = (r.st != SWR_SLEEP);
	assign o_usb_xcvr_en = (r.st != SWR_SLEEP);
	assign o_read_dummy = r.dummy;
	assign o_host_port_interrupt = r.evt[`SWR_EVT_HPINT];
	assign o_usb_reg_reset = r.usbrst;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	a_sleep_entry: assert property (r.st == SWR_RUN &&
		n.pwr[`SWR_PWR_SLEEP] && i_reset_pin_n |=>
		r.st == SWR_SLEEP && !o_cpu_run)
		else $error("sleep bit did not enter sleep");
	a_gpio_held: assert property (r.st == SWR_SLEEP |->
		o_gpio_hold && o_gpio_test_oe == 25'h0)
		else $error("gpio not held while asleep");
	a_mem_addr_low: assert property (r.st == SWR_SLEEP |->
		o_mem_addr == `SWR_ZERO16)
		else $error("memory address not low in sleep");
	a_power_down: assert property ($rose(o_gpio_hold) |->
		!o_pll_en && !o_crystal_output_en &&
		!o_booster_en && !o_usb_xcvr_en)
		else $error("clocks or analog still on in sleep");
	a_disabled_ignored: assert property (r.st == SWR_SLEEP &&
		!any_wake && i_reset_pin_n |=> r.st == SWR_SLEEP)
		else $error("woke without enabled source");
	a_wake_event: assert property (r.st == SWR_SLEEP &&
		any_wake && i_reset_pin_n |=>
		r.st == SWR_WAKE ##0 !r.pwr[`SWR_PWR_SLEEP])
		else $error("enabled event did not wake");
	a_resume_bound: assert property (r.st == SWR_WAKE &&
		r.cnt == BOOT_LAST && i_reset_pin_n |=> o_cpu_run)
		else $error("resume exceeds wake delay");
	a_dummy_read: assert property (r.st == SWR_SLEEP &&
		read_wake && i_reset_pin_n |=> o_read_dummy ##1 !o_read_dummy)
		else $error("read wake not flagged dummy");
	a_resume_int: assert property (r.st == SWR_SLEEP &&
		usb_wake && i_reset_pin_n |=> o_host_port_interrupt)
		else $error("host interrupt missing on usb resume");
	a_pin_defaults: assert property (r.st == SWR_PINRST |->
		r.speed == `SWR_SPEED_RST && r.pwr == `SWR_ZERO16 &&
		r.bank == `SWR_BANK_RST)
		else $error("pin reset left non default register");
	a_boot_vector: assert property ($rose(o_cpu_start) |->
		o_start_addr == `SWR_ROM_ENTRY ##1
		o_gpio_test_oe == `SWR_TEST_GPIO)
		else $error("boot start or test drive wrong");
	a_flags_ro: assert property (i_psel && i_penable &&
		!i_pwrite && i_paddr == `SWR_BYTE(`SWR_IDX_FLAGS) |->
		o_prdata[31:5] == 27'h0)
		else $error("flags upper bits not zero");
	a_cpu_div: assert property (o_cpu_clk_en &&
		r.speed[3:0] != 4'h0 && $stable(r.st) |=> !o_cpu_clk_en)
		else $error("cpu clock enable not divided");

	c_sleep: cover property (r.st == SWR_RUN ##1 r.st == SWR_SLEEP);
	c_wake: cover property (r.st == SWR_SLEEP ##1 r.st == SWR_WAKE);
	c_boot: cover property (o_cpu_start);
	c_bad_addr: cover property (o_pslverr);

endmodule // swr_sleep_ctrl

/* verification/swr_wake_partner.sv */
// Far side of the wake inputs: USB bus, OTG pins, outside readers and the interrupt zero input.
module swr_wake_partner
(
	input  wire logic       i_ref_clk,
	input  wire logic [2:0] i_cmd,
	input  wire logic       i_go,
	output logic            o_usb1,
	output logic            o_usb2,
	output logic            o_supply,
	output logic            o_ident,
	output logic            o_host_rd,
	output logic            o_fast_rd,
	output logic            o_spi_rd,
	output logic            o_int0
);
	timeunit 1ns;
	timeprecision 1ps;

	logic go_q;
	logic fire;

	assign fire = i_go & ~go_q;

	initial
	begin
		{go_q, o_usb1, o_usb2, o_supply, o_ident} = 4'h0;
		{o_host_rd, o_fast_rd, o_spi_rd, o_int0} = 4'h0;
	end

	// Resume signalling and the supply level stand while commanded.
	always @(posedge i_ref_clk)
	begin
		go_q <= i_go;
		o_usb1 <= i_go && i_cmd == 3'h0;
		o_usb2 <= i_go && i_cmd == 3'h1;
		o_supply <= i_go && i_cmd == 3'h2;
		if (fire && i_cmd == 3'h3)
			o_ident <= ~o_ident;
		if (fire && i_cmd == 3'h7)
			o_int0 <= ~o_int0;
		// Read pulses carry no data, so a dummy answer is simply dropped.
		o_host_rd <= fire && i_cmd == 3'h4;
		o_fast_rd <= fire && i_cmd == 3'h5;
		o_spi_rd <= fire && i_cmd == 3'h6;
	end
endmodule // swr_wake_partner

/* verification/sleep_wake_reset_cpu_ctrl_tb.sv */
`include "swr_map.svh"

module sleep_wake_reset_cpu_ctrl_tb
	import swr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int BOOT = 50;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        alu_valid, alu_sub, gie, ctrl_sel, rom_sel, clk_en;
	logic [15:0] alu_a, alu_b, cpu_addr, start_addr, mem_in, mem_out;
	logic        cpu_run, cpu_start, pin_n, gpio_hold, boost_ok, pump_on;
	logic [24:0] test_oe;
	logic        xtal_en, pll_en, boost_en, xcvr_en, dummy, host_int;
	logic        usb1, usb2, supply, ident, host_rd, fast_rd, spi_rd, int0;
	logic        usb_rst, usb_reg_rst, go;
	logic [2:0]  cmd;
	int          num_errors = 0;
	int          cmp_count = 0;
	int          n_dummy = 0;

	swr_sleep_ctrl #(.BOOT_CYC(BOOT), .TEST_CYC(20)) u_dut (
		.i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_alu_valid(alu_valid), .i_alu_sub(alu_sub),
		.i_alu_a(alu_a), .i_alu_b(alu_b), .i_global_int_en(gie),
		.i_cpu_addr(cpu_addr), .o_ctrl_sel(ctrl_sel), .o_rom_sel(rom_sel),
		.o_cpu_clk_en(clk_en), .o_cpu_run(cpu_run),
		.o_cpu_start(cpu_start), .o_start_addr(start_addr),
		.i_reset_pin_n(pin_n), .i_mem_addr(mem_in), .o_mem_addr(mem_out),
		.o_gpio_hold(gpio_hold), .o_gpio_test_oe(test_oe),
		.o_crystal_output_en(xtal_en), .o_pll_en(pll_en),
		.o_booster_en(boost_en), .o_usb_xcvr_en(xcvr_en),
		.i_boost_ok(boost_ok), .i_charge_pump_on(pump_on),
		.i_usb1_resume(usb1), .i_usb2_resume(usb2),
		.i_otg_bus_supply(supply), .i_otg_identify_input(ident),
		.i_parallel_host_port_rd(host_rd), .i_fast_serial_port_rd(fast_rd),
		.i_spi_rd(spi_rd), .i_interrupt_zero_input(int0),
		.o_read_dummy(dummy), .o_host_port_interrupt(host_int),
		.i_usb_bus_reset(usb_rst), .o_usb_reg_reset(usb_reg_rst));

	swr_wake_partner u_part (
		.i_ref_clk(clk), .i_cmd(cmd), .i_go(go), .o_usb1(usb1),
		.o_usb2(usb2), .o_supply(supply), .o_ident(ident),
		.o_host_rd(host_rd), .o_fast_rd(fast_rd), .o_spi_rd(spi_rd),
		.o_int0(int0));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
		if (dummy === 1'b1)
			n_dummy <= n_dummy + 1;

	task automatic complete_run();
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			num_errors++;
			$display("unexpected at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask

	// The bus request stands until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [17:0] i,
		input logic [15:0] d, output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= `SWR_BYTE(i);
		pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [17:0] i, input logic [15:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, i, d, r, e);
	endtask

	task automatic rd(input logic [17:0] i, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, i, 16'h0000, r, e);
		chk(r, x);
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wait_for(input logic strt);
		int n;
		n = 0;
		while (((strt ? cpu_start : cpu_run) !== 1'b1) && n < BOOT + 20)
		begin
			@(negedge clk);
			n++;
		end
		chk(strt ? cpu_start : cpu_run, 1);
	endtask

	task automatic fire(input logic [2:0] c);
		@(posedge clk);
		cmd <= c;
		go <= 1'b1;
		repeat (3) @(posedge clk);
		go <= 1'b0;
	endtask

	logic [15:0] ta[4] = '{16'h7fff, 16'h0005, 16'h0000, 16'hffff};
	logic [15:0] tb[4] = '{16'h0001, 16'h0005, 16'h0001, 16'h0001};
	logic [3:0]  tf[4] = '{4'hc, 4'h1, 4'ha, 4'h3};
	logic [15:0] ad[4] = '{16'hc0ff, 16'he000, 16'hbfff, 16'hc100};
	logic [1:0]  sx[4] = '{2'h2, 2'h1, 2'h0, 2'h0};
	logic [15:0] enb[8] = '{16'h1000, 16'h4000, 16'h0800, 16'h0800,
		16'h0080, 16'h0200, 16'h0100, 16'h0010};

	initial
	begin
		int          c;
		int          d0;
		logic [31:0] r;
		logic        e;
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{alu_valid, alu_sub, alu_a, alu_b, cpu_addr} = '0;
		{usb_rst, go, cmd, pump_on} = '0;
		{gie, boost_ok, pin_n} = 3'h7;
		mem_in = 16'hbeef;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(`SWR_IDX_BANK, 32'h0100);
		rd(`SWR_IDX_SPEED, 32'h000f);
		rd(`SWR_IDX_PWR, 32'h0004);
		wr(`SWR_IDX_REV, 16'hffff);
		rd(`SWR_IDX_REV, `SWR_REV_VALUE);
		apb(1'b0, 18'h0c006, 16'h0000, r, e);
		chk({e, r[30:0]}, 32'h80000000);
		wr(`SWR_IDX_BKPT, 16'habcd);
		rd(`SWR_IDX_BKPT, 32'habcd);
		wr(`SWR_IDX_INTEN, 16'h1234);
		rd(`SWR_IDX_INTEN, 32'h1234);
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk);
			cpu_addr <= ad[k];
			step(2);
			chk({ctrl_sel, rom_sel}, sx[k]);
		end
		wait_for(1'b0);
		chk(mem_out, 16'hbeef);
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk);
			{alu_valid, alu_a, alu_b} <= {1'b1, ta[k], tb[k]};
			alu_sub <= k[1] ^ k[0];
			@(posedge clk);
			alu_valid <= 1'b0;
			rd(`SWR_IDX_FLAGS, {27'h0, 1'b1, tf[k]});
		end
		wr(`SWR_IDX_FLAGS, 16'hffff);
		gie <= 1'b0;
		rd(`SWR_IDX_FLAGS, 32'h0003);
		wr(`SWR_IDX_SPEED, 16'hfff3);
		rd(`SWR_IDX_SPEED, 32'h0003);
		c = 0;
		repeat (40)
		begin
			@(negedge clk);
			if (clk_en === 1'b1)
				c++;
		end
		chk(c, 10);
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clk);
			pump_on <= (k == 0);
			boost_ok <= k[0];
			wr(`SWR_IDX_PWR, 16'h0002 | enb[k]);
			step(2);
			chk({xtal_en, pll_en, boost_en, xcvr_en}, 0);
			chk({gpio_hold, mem_out}, 32'h10000);
			chk({cpu_run, clk_en}, 0);
			fire(3'(k + 4));
			step(5);
			chk(pll_en, 0);
			d0 = n_dummy;
			fire(3'(k));
			wait_for(1'b0);
			chk({xtal_en, pll_en, boost_en, xcvr_en}, 4'hf);
			rd(`SWR_IDX_DIAG, enb[k]);
			chk(n_dummy - d0, k inside {4, 5, 6});
			rd(`SWR_IDX_EVT, {30'h0, k == 0, k < 2});
			rd(`SWR_IDX_PWR, enb[k] | {13'h0, k[0], 2'h0});
			wr(`SWR_IDX_EVT, 16'h0003);
			step(1);
			chk(host_int, 0);
		end
		wr(`SWR_IDX_DIAG, 16'h5555);
		rd(`SWR_IDX_DIAG, 32'h0010);
		wr(`SWR_IDX_BANK, 16'h1235);
		@(posedge clk);
		usb_rst <= 1'b1;
		@(posedge clk);
		usb_rst <= 1'b0;
		@(negedge clk);
		chk(usb_reg_rst, 1);
		rd(`SWR_IDX_BANK, 32'h1230);
		@(posedge clk);
		pin_n <= 1'b0;
		repeat (20) @(posedge clk);
		pin_n <= 1'b1;
		rd(`SWR_IDX_BANK, 32'h1230);
		chk(cpu_run, 1);
		@(posedge clk);
		pin_n <= 1'b0;
		repeat (140) @(posedge clk);
		pin_n <= 1'b1;
		rd(`SWR_IDX_BANK, 32'h0100);
		wait_for(1'b1);
		chk(start_addr, `SWR_ROM_ENTRY);
		step(2);
		chk(test_oe, `SWR_TEST_GPIO);
		step(25);
		chk(test_oe, 0);
		wait_for(1'b0);
		complete_run();
	end

	initial
	begin
		#200000;
		num_errors++;
		complete_run();
	end
endmodule // sleep_wake_reset_cpu_ctrl_tb
